// ---- ddr_port_pkg.sv ----
// constants shared by the burst-of-two ddr sram port and its write log
// assumes nothing of its surroundings; imported whole by the design
`default_nettype none
package ddr_port_pkg;
   // ----------------------------------------------------------------
   // word and burst shape
   // ----------------------------------------------------------------
   localparam int DATA_W_NARROW = 18;
   localparam int DATA_W_WIDE = 36;
   localparam int BURST_LEN = 2;
   localparam int ADDR_W_DEF = 4;
   // ----------------------------------------------------------------
   // read latency in half clock periods, per latency mode
   // ----------------------------------------------------------------
   localparam int RD_LAT_PLL_HALF = 3;
   localparam int RD_LAT_LEGACY_HALF = 2;
   // ----------------------------------------------------------------
   // write log buffer and reset values
   // ----------------------------------------------------------------
   localparam int LOG_DEPTH = 16;
   localparam logic LAT_PLL_RST = 1'b1;
   localparam logic TGL_RST = 1'b0;
endpackage : ddr_port_pkg
`default_nettype wire

// ---- ddr_burst2_sram_port.sv ----
// burst-of-two ddr sram port: input capture, flop array, ddr read launch,
// echo clocks and a write log crossing into the ref_clk domain via a fifo
// assumes out_clk/out_clk_n are in phase with k_clk/kn_clk; in single
// clock mode the bench ties out_clk to k_clk and out_clk_n to kn_clk
//
// Overview of operation
// - addresses taken on alternate rising k edges, at most every second edge
// - only rising edges of k_clk and kn_clk are used for sampling
// - write words sampled on rising k_clk then rising kn_clk
// - read words launched on rising out_clk and out_clk_n
// - burst counter loads low address bit, sequences two words per access
// - burst word is 18 or 36 bits wide, two words per burst
// - pll disable pin high gives first read word 1.5 cycles after address
// - pll disable pin low gives first read word one cycle after address
// - address, control and write data pass input registers before use
// - data outputs come from registers on the output clock pair
// - read and write data share one bus; device drives only for reads
// - complementary echo clocks accompany the read data
// - array write completes internally once address and both words are held
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// synchronous fifo with valid/ready on both sides
// ------------------------------------------------------------------
module log_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0] wr_ptr_r;
   logic [PW-1:0] rd_ptr_r;
   logic [PW:0] count_r;
   logic push;
   logic pop;

   // honest full and empty from the occupancy count
   assign in_ready = (count_r != DEPTH[PW:0]);
   assign out_valid = (count_r != '0);
   assign out_data = mem_r[rd_ptr_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // storage and pointers
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule : log_fifo

// ------------------------------------------------------------------
// top of the sram port
// ------------------------------------------------------------------
module ddr_burst2_sram_port
   import ddr_port_pkg::*;
#(
   parameter int DATA_W = DATA_W_NARROW,
   parameter int ADDR_W = ADDR_W_DEF,
   parameter int LOG_D = LOG_DEPTH
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic k_clk,
   input wire logic kn_clk,
   input wire logic out_clk,
   input wire logic out_clk_n,
   input wire logic ld_n,
   input wire logic rw,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] dq_in,
   output logic [DATA_W-1:0] dq_out,
   output logic dq_oe,
   input wire logic pll_disable_pin,
   output logic echo_clock_out,
   output logic echo_clock_out_n,
   output logic log_valid,
   input wire logic log_ready,
   output logic [ADDR_W-1:0] log_addr,
   output logic [DATA_W-1:0] log_word0,
   output logic [DATA_W-1:0] log_word1
);
   // two DATA_W words per burst entry
   localparam int LOG_W = ADDR_W + 2 * DATA_W;

   // second burst address: lowest bit inverted
   function automatic logic [ADDR_W-1:0] burst_next(input logic [ADDR_W-1:0] a);
      burst_next = {a[ADDR_W-1:1], ~a[0]};
   endfunction : burst_next

   // ----------------------------------------------------------------
   // link-side reset and latency-mode pin synchronisers
   // ----------------------------------------------------------------
   logic rst_s1_r;
   logic k_rst;
   logic pll_s1_r;
   logic pll_s2_r;
   logic pll_s3_r;
   logic lat_pll_r;

   // reset is brought into the k domain by two flops
   always_ff @(posedge k_clk) begin
      rst_s1_r <= sys_rst;
      k_rst <= rst_s1_r;
   end

   // pin passes three flops; a change counts when the last two agree
   always_ff @(posedge k_clk) begin
      pll_s1_r <= pll_disable_pin;
      pll_s2_r <= pll_s1_r;
      pll_s3_r <= pll_s2_r;
      if (k_rst) begin
         lat_pll_r <= LAT_PLL_RST;
      end else if (pll_s2_r == pll_s3_r) begin
         lat_pll_r <= pll_s3_r;
      end
   end

   // ----------------------------------------------------------------
   // input registers and address acceptance
   // ----------------------------------------------------------------
   logic ld_n_r;
   logic rw_r;
   logic [ADDR_W-1:0] addr_r;
   logic [DATA_W-1:0] din_k_r;
   logic [DATA_W-1:0] din_kn_r;
   logic blk_r;
   logic acc;
   logic rd_go;
   logic rd_go2_r;
   logic wr_go2_r;
   logic [ADDR_W-1:0] op_a_r;
   logic [DATA_W-1:0] mem_r [2**ADDR_W];

   always_ff @(posedge k_clk) begin
      if (k_rst) begin
         ld_n_r <= 1'b1;
         rw_r <= 1'b1;
         addr_r <= '0;
         din_k_r <= '0;
      end else begin
         ld_n_r <= ld_n;
         rw_r <= rw;
         addr_r <= addr;
         din_k_r <= dq_in;
      end
   end

   // second write word on the complementary rising edge
   always_ff @(posedge kn_clk) begin
      if (k_rst) begin
         din_kn_r <= '0;
      end else begin
         din_kn_r <= dq_in;
      end
   end

   // an accepted address blocks the next edge
   assign acc = !ld_n_r && !blk_r;
   assign rd_go = acc && rw_r;

   // operation tracking across the burst
   always_ff @(posedge k_clk) begin
      if (k_rst) begin
         blk_r <= 1'b0;
         rd_go2_r <= 1'b0;
         wr_go2_r <= 1'b0;
         op_a_r <= '0;
      end else begin
         blk_r <= acc;
         rd_go2_r <= rd_go;
         wr_go2_r <= acc && !rw_r;
         // burst counter loads the low address bit here
         if (acc) begin
            op_a_r <= addr_r;
         end
      end
   end

   // self-timed array write once both words are held
   always_ff @(posedge k_clk) begin
      if (wr_go2_r) begin
         // second word at the inverted low bit
         mem_r[op_a_r] <= din_k_r;
         mem_r[burst_next(op_a_r)] <= din_kn_r;
      end
   end

   // ----------------------------------------------------------------
   // read launch on the output clock pair
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] q_c_r;
   logic [DATA_W-1:0] q_cn_r;
   logic oe_c_r;
   logic oe_cn_r;

   // rising out_clk: first word (legacy) or second word (pll)
   always_ff @(posedge out_clk) begin
      if (k_rst) begin
         q_c_r <= '0;
         oe_c_r <= 1'b0;
      end else if (!lat_pll_r && rd_go) begin
         q_c_r <= mem_r[addr_r];
         oe_c_r <= 1'b1;
      end else if (lat_pll_r && rd_go2_r) begin
         q_c_r <= mem_r[burst_next(op_a_r)];
         oe_c_r <= 1'b1;
      end else begin
         oe_c_r <= 1'b0;
      end
   end

   // rising out_clk_n: second word (legacy) or first word (pll)
   always_ff @(posedge out_clk_n) begin
      if (k_rst) begin
         q_cn_r <= '0;
         oe_cn_r <= 1'b0;
      end else if (rd_go2_r) begin
         // 1.5 cycle latency puts the first word here
         q_cn_r <= lat_pll_r ? mem_r[op_a_r] : mem_r[burst_next(op_a_r)];
         oe_cn_r <= 1'b1;
      end else begin
         oe_cn_r <= 1'b0;
      end
   end

   // ddr output: high phase shows the out_clk register
   assign dq_out = out_clk ? q_c_r : q_cn_r;
   // bus driven only while read words are out
   assign dq_oe = out_clk ? oe_c_r : oe_cn_r;
   // echo clocks follow the launch clocks
   assign echo_clock_out = out_clk;
   assign echo_clock_out_n = out_clk_n;

   // ----------------------------------------------------------------
   // write log crossing: toggle handshake into ref_clk, then fifo
   // ----------------------------------------------------------------
   logic log_tgl_r;
   logic [LOG_W-1:0] log_hold_r;
   logic ack_s1_r;
   logic ack_s2_r;
   logic ack_s3_r;
   logic ack_k_r;
   logic tgl_s1_r;
   logic tgl_s2_r;
   logic tgl_s3_r;
   logic tgl_ref_r;
   logic ack_r;
   logic fifo_in_ready;
   logic [LOG_W-1:0] fifo_out;

   // k side: capture a finished write when the last one was taken
   always_ff @(posedge k_clk) begin
      if (k_rst) begin
         log_tgl_r <= TGL_RST;
         log_hold_r <= '0;
      end else if (wr_go2_r && (log_tgl_r == ack_k_r)) begin
         log_tgl_r <= ~log_tgl_r;
         log_hold_r <= {op_a_r, din_k_r, din_kn_r};
      end
   end

   // ack from ref domain, three flops with agreement
   always_ff @(posedge k_clk) begin
      ack_s1_r <= ack_r;
      ack_s2_r <= ack_s1_r;
      ack_s3_r <= ack_s2_r;
      if (k_rst) begin
         ack_k_r <= TGL_RST;
      end else if (ack_s2_r == ack_s3_r) begin
         ack_k_r <= ack_s3_r;
      end
   end

   // ref side: see the toggle, push when the fifo has room
   always_ff @(posedge ref_clk) begin
      tgl_s1_r <= log_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
      if (sys_rst) begin
         tgl_ref_r <= TGL_RST;
         ack_r <= TGL_RST;
      end else begin
         if (tgl_s2_r == tgl_s3_r) begin
            tgl_ref_r <= tgl_s3_r;
         end
         if ((tgl_ref_r != ack_r) && fifo_in_ready) begin
            ack_r <= tgl_ref_r;
         end
      end
   end

   log_fifo #(
      .WIDTH(LOG_W),
      .DEPTH(LOG_D)
   ) u_log_fifo (
      .clk(ref_clk),
      .rst(sys_rst),
      .in_valid(tgl_ref_r != ack_r),
      .in_ready(fifo_in_ready),
      .in_data(log_hold_r),
      .out_valid(log_valid),
      .out_ready(log_ready),
      .out_data(fifo_out)
   );

   // split the log word into its fields
   assign log_addr = fifo_out[LOG_W-1 -: ADDR_W];
   assign log_word0 = fifo_out[2*DATA_W-1 -: DATA_W];
   assign log_word1 = fifo_out[DATA_W-1:0];

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_addr_alternate: assert property (
      @(posedge k_clk) disable iff (k_rst) acc |=> !acc)
      else $error("address accepted on two adjacent edges");

   a_second_word_sample: assert property (
      @(posedge kn_clk) disable iff (k_rst) wr_go2_r |=> din_kn_r == $past(dq_in))
      else $error("second write word not sampled on kn edge");

   a_first_word_store: assert property (
      @(posedge k_clk) disable iff (k_rst) wr_go2_r |=> mem_r[$past(op_a_r)] == $past(din_k_r))
      else $error("first write word not at burst start");

   a_second_word_addr: assert property (
      @(posedge k_clk) disable iff (k_rst)
      wr_go2_r |=> mem_r[burst_next($past(op_a_r))] == $past(din_kn_r))
      else $error("second write word not at inverted low bit");

   a_pll_latency: assert property (
      @(posedge k_clk) disable iff (k_rst) (rd_go && lat_pll_r) |=> !oe_c_r ##1 oe_c_r)
      else $error("pll mode read not at 1.5 cycles");

   a_legacy_latency: assert property (
      @(posedge k_clk) disable iff (k_rst)
      (rd_go && !lat_pll_r) |=> oe_c_r && (q_c_r == mem_r[$past(addr_r)]))
      else $error("legacy mode read not at one cycle");

   a_bus_release: assert property (
      @(posedge k_clk) disable iff (k_rst) (!rd_go && !rd_go2_r) |=> !oe_c_r)
      else $error("bus driven without a read");

   a_write_commit: assert property (
      @(posedge k_clk) disable iff (k_rst) (acc && !rw_r) |=> wr_go2_r ##1 !wr_go2_r)
      else $error("write commit not one edge after address");
endmodule : ddr_burst2_sram_port
`default_nettype wire

// ---- ddr_ctrl_model.sv ----
// memory controller model: makes the k clock pair and drives the address
// and write data; assumes the bench resolves the shared data bus
`timescale 1ns/1ps
`default_nettype none
module ddr_ctrl_model
   import ddr_port_pkg::*;
#(
   parameter int DATA_W = DATA_W_NARROW,
   parameter int ADDR_W = ADDR_W_DEF
) (
   output var logic k_clk,
   output logic kn_clk,
   output var logic ld_n,
   output var logic rw,
   output var logic [ADDR_W-1:0] addr,
   output var logic [DATA_W-1:0] dq_drv
);
   // ----------------------------------------------------------------
   // free running k pair, 48 ns, phase unrelated to ref_clk
   // ----------------------------------------------------------------
   initial begin
      k_clk = 1'b0;
      ld_n = 1'b1;
      rw = 1'b1;
      addr = '0;
      dq_drv = '0;
      #7;
      forever #24 k_clk = ~k_clk;
   end
   assign kn_clk = ~k_clk;
   // ----------------------------------------------------------------
   // bus tasks
   // ----------------------------------------------------------------
   // one address per two edges; with twice, ld_n is held low for a second load of ~a on the next edge
   task cmd(input logic r, input logic [ADDR_W-1:0] a, input logic twice);
      @(posedge k_clk);
      ld_n <= 1'b0;
      rw <= r;
      addr <= a;
      @(posedge k_clk);
      ld_n <= ~twice;
      addr <= ~a;
   endtask : cmd
   // stop a held address load
   task idle();
      ld_n <= 1'b1;
   endtask : idle
   // one word per rising edge of each clock, then drive the second word inverted
   task data(input logic [DATA_W-1:0] d0, input logic [DATA_W-1:0] d1);
      dq_drv <= d0;
      @(posedge k_clk);
      dq_drv <= d1;
      @(posedge kn_clk);
      dq_drv <= ~d1;
   endtask : data
endmodule : ddr_ctrl_model
`default_nettype wire

// ---- ddr_burst2_sram_port_tb.sv ----
// testbench of the burst-of-two sram port in single clock mode
// assumes the controller model drives the k side; bench owns ref_clk side
`timescale 1ns/1ps
`default_nettype none
module ddr_burst2_sram_port_tb;
   import ddr_port_pkg::*;
   logic ref_clk, sys_rst, log_ready, pll_disable_pin;
   wire logic k_clk, kn_clk, ld_n, rw, dq_oe, echo_clock_out, echo_clock_out_n, log_valid;
   wire logic [3:0] addr, log_addr;
   wire logic [17:0] dq_in, dq_out, dq_drv, log_word0, log_word1;
   int fail_count = 0;
   int cmp_count = 0;
   // shared bus: device wins while it drives
   assign dq_in = dq_oe ? dq_out : dq_drv;
   ddr_ctrl_model ddr_ctrl_model_inst (.k_clk(k_clk), .kn_clk(kn_clk), .ld_n(ld_n), .rw(rw),
      .addr(addr), .dq_drv(dq_drv));
   ddr_burst2_sram_port ddr_burst2_sram_port_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .k_clk(k_clk), .kn_clk(kn_clk), .out_clk(k_clk), .out_clk_n(kn_clk), .ld_n(ld_n),
      .rw(rw), .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
      .pll_disable_pin(pll_disable_pin), .echo_clock_out(echo_clock_out),
      .echo_clock_out_n(echo_clock_out_n), .log_valid(log_valid), .log_ready(log_ready),
      .log_addr(log_addr), .log_word0(log_word0), .log_word1(log_word1));
   // ----------------------------------------------------------------
   // compare and report
   // ----------------------------------------------------------------
   task chk_w(input logic [17:0] e, input logic [17:0] g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : chk_w
   task chk_b(input logic e, input logic g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : chk_b
   task close_out();
      $display("cmp_count=%0d fail_count=%0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out
   // ----------------------------------------------------------------
   // scenario tasks
   // ----------------------------------------------------------------
   task wr(input logic [3:0] a, input logic [17:0] d0, input logic [17:0] d1);
      ddr_ctrl_model_inst.cmd(1'b0, a, 1'b0);
      ddr_ctrl_model_inst.data(d0, d1);
   endtask : wr
   // read burst, word timing per latency mode, optional refused second load
   task rd(input logic [3:0] a, input logic [17:0] e0, input logic [17:0] e1, input logic pll,
      input logic twice);
      ddr_ctrl_model_inst.cmd(1'b1, a, twice);
      @(posedge k_clk);
      if (twice) ddr_ctrl_model_inst.idle();
      #1;
      if (pll) begin
         chk_b(1'b0, dq_oe);
         @(k_clk);
         #1;
      end
      chk_b(1'b1, dq_oe);
      chk_w(e0, dq_out);
      #10;
      chk_w(e0, dq_out);
      chk_b(k_clk, echo_clock_out);
      chk_b(kn_clk, echo_clock_out_n);
      @(k_clk);
      #1;
      chk_w(e1, dq_out);
      #10;
      chk_w(e1, dq_out);
      chk_b(1'b1, dq_oe);
      @(k_clk);
      #1;
      chk_b(1'b0, dq_oe);
   endtask : rd
   // wait for a log entry, compare it, pop it
   task log_pop(input logic [3:0] a, input logic [17:0] d0, input logic [17:0] d1);
      int i;
      for (i = 0; i < 60; i++) begin
         @(negedge ref_clk);
         if (log_valid === 1'b1) break;
      end
      if (i == 60) begin
         fail_count++;
         close_out();
      end
      chk_w({14'h0000, a}, {14'h0000, log_addr});
      chk_w(d0, log_word0);
      chk_w(d1, log_word1);
      @(posedge ref_clk);
      log_ready <= 1'b1;
      @(posedge ref_clk);
      log_ready <= 1'b0;
   endtask : log_pop
   task sc_mode(input logic pll);
      @(posedge ref_clk);
      pll_disable_pin <= pll;
      repeat (6) @(posedge k_clk);
      chk_w(18'(DATA_W_NARROW), 18'($bits(dq_out)));
      wr(4'h3, 18'h1_2345, 18'h2_abcd);
      log_pop(4'h3, 18'h1_2345, 18'h2_abcd);
      rd(4'h3, 18'h1_2345, 18'h2_abcd, pll, 1'b0);
      rd(4'h2, 18'h2_abcd, 18'h1_2345, pll, 1'b1);
   endtask : sc_mode
   // fill the log with the consumer stalled, then drain it
   task sc_fill();
      for (int i = 0; i < 16; i++) begin
         wr(4'(i), 18'(i), ~18'(i));
         repeat (10) @(posedge ref_clk);
      end
      for (int i = 0; i < 16; i++) log_pop(4'(i), 18'(i), ~18'(i));
      repeat (10) @(negedge ref_clk);
      chk_b(1'b0, log_valid);
   endtask : sc_fill
   // ----------------------------------------------------------------
   // clock, reset, main sequence
   // ----------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   initial begin
      sys_rst = 1'b1;
      log_ready = 1'b0;
      pll_disable_pin = 1'b1;
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      sc_mode(1'b1);
      sc_mode(1'b0);
      sc_fill();
      close_out();
   end
endmodule : ddr_burst2_sram_port_tb
`default_nettype wire
